// ---- rtl/anadv_pkg.sv ----
// Package with register map, field layout and bus carriers for the advertisement register
package anadv_pkg;

  // ********************************************************************
  // Register map and field layout
  // ********************************************************************
  localparam logic [3:0] ANADV_ADV_OFFSET = 4'h4;       // Advertisement register index
  localparam logic [3:0] ANADV_CTL_OFFSET = 4'h0;       // Control register index (restart bit)
  localparam logic [3:0] ANADV_ACT_OFFSET = 4'h1;       // Active advertisement readback index
  localparam logic [15:0] ANADV_ADV_RESET = 16'h01E1;   // Advertisement reset value
  localparam logic [15:0] ANADV_WR_MASK = 16'h21E0;     // Writable bits: 13 and 8:5
  localparam logic [4:0] ANADV_SELECTOR = 5'h01;        // Fixed selector code
  localparam int ANADV_SEL_LSB = 0;                     // Selector field low bit
  localparam int ANADV_SEL_MSB = 4;                     // Selector field high bit
  localparam int ANADV_ABIL_LSB = 5;                    // Ability field low bit
  localparam int ANADV_ABIL_MSB = 8;                    // Ability field high bit
  localparam int ANADV_RF_BIT = 13;                     // Remote fault bit
  localparam int ANADV_NP_BIT = 15;                     // Next page bit
  localparam int ANADV_RESTART_BIT = 9;                 // Restart bit in control register
  localparam logic [31:0] ANADV_UNMAPPED = 32'h00000000; // Read data of unmapped index

  // ********************************************************************
  // Bus carriers
  // ********************************************************************
  typedef struct packed {
    logic [5:0] address;     // Word address
    logic read;              // Read request
    logic write;             // Write request
    logic [3:0] byteenable;  // Byte lanes
    logic [31:0] writedata;  // Write data
  } anadv_req_type;

  typedef struct packed {
    logic [31:0] readdata;   // Read data
    logic waitrequest;       // Stall
  } anadv_rsp_type;

  // Abilities as offered to the link partner
  typedef struct packed {
    logic next_page_bit;
    logic remote_fault_advert_bit;
    logic ability_100_full;
    logic ability_100_half;
    logic ability_10_full;
    logic ability_10_half;
    logic [4:0] selector;
  } anadv_adv_type;

endpackage : anadv_pkg

// ---- rtl/anadv_reg.sv ----
// Auto-negotiation advertisement register with Avalon-MM slave and restart latch
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
// What this block does
// - Bits 8:5 carry the abilities 100TX full, 100TX half, 10T full, 10T half.
// - Software can overwrite the ability bits to narrow what is negotiated.
// - Writes do not change the active advertisement until the restart bit is set.
// - At reset the register at index 0x04 reads 0x01E1.
// - Writable bit 13 sends a remote fault to the partner and clears at reset.
// - Writable bit 7 offers 100TX half duplex and is set at reset.
// - The selector field in bits 4:0 is fixed at 0x01 and ignores writes.
module anadv_reg (
  input wire logic mclk,                           // System clock, 200 MHz
  input wire logic reset_n,                        // Asynchronous reset, active low
  input wire anadv_pkg::anadv_req_type bus_req,    // Avalon-MM request
  output anadv_pkg::anadv_rsp_type bus_rsp,        // Avalon-MM response
  output anadv_pkg::anadv_adv_type adv_active,     // Abilities offered to the partner
  output logic restart_negotiation_pulse           // One cycle restart strobe to the engine
);
  import anadv_pkg::*;

  // ********************************************************************
  // State
  // ********************************************************************
  logic [15:0] advertisement_register_ff;
  logic [15:0] nxt_advertisement_register;
  logic [15:0] active_adv_ff;
  logic [15:0] nxt_active_adv;
  logic done_ff;
  logic nxt_done;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic restart_ff;
  logic nxt_restart;
  logic waitreq_ff;
  logic nxt_waitreq;
  logic commit;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic access;

  // Lane strobes and write merge
  assign wr_lo = bus_req.byteenable[0];
  assign wr_hi = bus_req.byteenable[1];
  assign wmask = {{8{wr_hi}}, {8{wr_lo}}} & ANADV_WR_MASK;
  assign wval = bus_req.writedata[15:0];
  assign access = (bus_req.read | bus_req.write) & ~done_ff;
  // A write lands only at the edge where waitrequest is seen low
  assign commit = bus_req.write & done_ff;

  // Next state: one wait cycle then the access completes
  always_comb begin
    nxt_advertisement_register = advertisement_register_ff;
    nxt_active_adv = active_adv_ff;
    nxt_done = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_restart = 1'b0;
    if (access) begin
      nxt_done = 1'b1;
      if (bus_req.read) begin
        unique case (bus_req.address[3:0])
          ANADV_ADV_OFFSET: nxt_rdata = {16'h0000, advertisement_register_ff};
          ANADV_ACT_OFFSET: nxt_rdata = {16'h0000, active_adv_ff};
          default: nxt_rdata = ANADV_UNMAPPED;
        endcase
        if (bus_req.address[5:4] != 2'h0) begin
          nxt_rdata = ANADV_UNMAPPED;
        end
      end
    end
    if (commit) begin
      begin
        unique case (bus_req.address[3:0])
          ANADV_ADV_OFFSET: begin
            // Only bits 13 and 8:5 take the write
            nxt_advertisement_register = (advertisement_register_ff & ~wmask) | (wval & wmask);
          end
          ANADV_CTL_OFFSET: begin
            if (wr_hi && wval[ANADV_RESTART_BIT]) begin
              nxt_restart = 1'b1;
              nxt_active_adv = advertisement_register_ff;
            end
          end
          default: begin
          end
        endcase
      end
      if (bus_req.address[5:4] != 2'h0) begin
        nxt_advertisement_register = advertisement_register_ff;
        nxt_active_adv = active_adv_ff;
        nxt_restart = 1'b0;
      end
    end
    nxt_waitreq = ~nxt_done;
  end

  // Registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      advertisement_register_ff <= ANADV_ADV_RESET;
      active_adv_ff <= ANADV_ADV_RESET;
      done_ff <= 1'b0;
      rdata_ff <= ANADV_UNMAPPED;
      restart_ff <= 1'b0;
      waitreq_ff <= 1'b1;
    end else begin
      advertisement_register_ff <= nxt_advertisement_register;
      active_adv_ff <= nxt_active_adv;
      done_ff <= nxt_done;
      rdata_ff <= nxt_rdata;
      restart_ff <= nxt_restart;
      waitreq_ff <= nxt_waitreq;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  // Waitrequest stays low only in the completion cycle
  assign bus_rsp.waitrequest = waitreq_ff;
  assign bus_rsp.readdata = rdata_ff;
  assign restart_negotiation_pulse = restart_ff;

  // Active advertisement field map
  assign adv_active.next_page_bit = active_adv_ff[ANADV_NP_BIT];
  assign adv_active.remote_fault_advert_bit = active_adv_ff[ANADV_RF_BIT];
  assign adv_active.ability_100_full = active_adv_ff[ANADV_ABIL_MSB];
  assign adv_active.ability_100_half = active_adv_ff[ANADV_ABIL_MSB - 1];
  assign adv_active.ability_10_full = active_adv_ff[ANADV_ABIL_LSB + 1];
  assign adv_active.ability_10_half = active_adv_ff[ANADV_ABIL_LSB];
  assign adv_active.selector = active_adv_ff[ANADV_SEL_MSB:ANADV_SEL_LSB];

endmodule : anadv_reg

// ---- dv/anadv_reg_checker.sv ----
// Checker of bus timing, fixed fields and advertisement hold
`timescale 1ns/100ps
module anadv_reg_checker (
  input wire logic mclk, // Clock
  input wire logic reset_n, // Reset
  input wire anadv_pkg::anadv_req_type bus_req, // Request
  input wire anadv_pkg::anadv_rsp_type bus_rsp, // Response
  input wire anadv_pkg::anadv_adv_type adv_active, // Offered page
  input wire logic restart_negotiation_pulse // Restart strobe
);
  import anadv_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Completion flags of reads
  logic rd_done;
  assign rd_done = bus_req.read && !bus_rsp.waitrequest;
  a_sel_fixed: assert property (adv_active.selector == 5'h01)
    else $error("selector changed");
  a_np_zero: assert property (!adv_active.next_page_bit)
    else $error("next page set");
  a_adv_hold: assert property (!restart_negotiation_pulse |-> $stable(adv_active))
    else $error("page moved without restart");
  a_one_wait: assert property (bus_req.read && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
    else $error("read not answered");
  a_idle_wait: assert property (!bus_req.read && !bus_req.write |=> bus_rsp.waitrequest)
    else $error("answer without request");
  a_ro_zero: assert property (rd_done && bus_req.address == 6'h04 |->
    (bus_rsp.readdata & 32'hFFFFDE1F) == 32'h00000001) else $error("fixed bits wrong");
  a_restart: assert property (bus_req.write && !bus_rsp.waitrequest && bus_req.address == 6'h00
    && bus_req.writedata[9] && bus_req.byteenable[1] |=> restart_negotiation_pulse)
    else $error("restart missing");
  a_active_rd: assert property (rd_done && bus_req.address == 6'h01 |->
    bus_rsp.readdata[15:0] == {adv_active.next_page_bit, 1'b0,
    adv_active.remote_fault_advert_bit, 4'h0, adv_active[8:0]}) else $error("active readback");
endmodule : anadv_reg_checker
bind anadv_reg anadv_reg_checker i_anadv_reg_checker (.mclk(mclk), .reset_n(reset_n),
  .bus_req(bus_req), .bus_rsp(bus_rsp), .adv_active(adv_active),
  .restart_negotiation_pulse(restart_negotiation_pulse));

// ---- dv/anadv_partner.sv ----
// Link partner that latches the base page when negotiation restarts
`timescale 1ns/100ps
module anadv_partner (
  input wire logic mclk, // Clock
  input wire anadv_pkg::anadv_adv_type adv_active, // Offered page
  input wire logic restart_negotiation_pulse, // Restart strobe
  output logic [15:0] rx_page // Page as received
);
  import anadv_pkg::*;
  // Take the page only on a restart
  always_ff @(posedge mclk) begin
    if (restart_negotiation_pulse === 1'b1) begin
      rx_page <= {adv_active.next_page_bit, 1'b0, adv_active.remote_fault_advert_bit,
        4'h0, adv_active[8:0]};
    end
  end
endmodule : anadv_partner

// ---- dv/tb_autoneg_advertisement_reg.sv ----
// Testbench of the advertisement register
`timescale 1ns/100ps
module tb_autoneg_advertisement_reg;
  import anadv_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  anadv_req_type req = '0;
  anadv_rsp_type rsp;
  anadv_adv_type adv;
  logic pulse;
  logic [15:0] rx;
  logic [31:0] q;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  anadv_reg i_anadv_reg (.mclk(mclk), .reset_n(reset_n), .bus_req(req), .bus_rsp(rsp),
    .adv_active(adv), .restart_negotiation_pulse(pulse));
  anadv_partner i_anadv_partner (.mclk(mclk), .adv_active(adv),
    .restart_negotiation_pulse(pulse), .rx_page(rx));
  // Clock and hang guard
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude;
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    req <= '{address: a, read: !w, write: w, byteenable: 4'h3, writedata: {16'h0000, d}};
    // Settled value before the edge is what that rising edge samples
    @(negedge mclk);
    while (rsp.waitrequest !== 1'b0) @(negedge mclk);
    q = rsp.readdata;
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask : bus
  task automatic t_reset;
    bus(1'b0, 6'h04, 16'h0000);
    chk(q, 32'h000001E1);
    bus(1'b1, 6'h02, 16'hFFFF);
    bus(1'b0, 6'h02, 16'h0000);
    chk(q, 32'h00000000);
  endtask : t_reset
  task automatic t_mask;
    bus(1'b1, 6'h04, 16'hFFFF);
    bus(1'b0, 6'h04, 16'h0000);
    chk(q, 32'h000021E1);
    bus(1'b0, 6'h01, 16'h0000);
    chk(q, 32'h000001E1);
    bus(1'b1, 6'h00, 16'h0200);
    bus(1'b0, 6'h01, 16'h0000);
    chk(q, 32'h000021E1);
    chk(rx, 16'h21E1);
  endtask : t_mask
  task automatic t_abil;
    for (int i = 5; i < 9; i++) begin
      bus(1'b1, 6'h04, 16'h0001 << i);
      bus(1'b1, 6'h00, 16'h0200);
      bus(1'b0, 6'h01, 16'h0000);
      chk(q, 32'h00000001 | (32'h00000001 << i));
      chk(rx, 16'h0001 | (16'h0001 << i));
    end
  endtask : t_abil
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_mask();
    t_abil();
    conclude();
  end
endmodule : tb_autoneg_advertisement_reg
